// *** hw/host_bus_port_pkg.sv ***
// Constants and types shared by the host bus port and its reset filter.
// Assumes one system clock; all pin levels arrive synchronous to it.

package host_bus_port_pkg;

   // =====================================================================
   // Bus geometry
   localparam int unsigned DATA_W = 8;

   // =====================================================================
   // Interface style strap levels
   localparam logic STYLE_STROBE = 1'b0;
   localparam logic STYLE_ENABLE = 1'b1;

   // =====================================================================
   // Data type select levels
   localparam logic TYPE_LOW  = 1'b0;
   localparam logic TYPE_HIGH = 1'b1;

   // =====================================================================
   // Reset values
   localparam logic [7:0] DATA_RST  = 8'h00;
   localparam logic       STYLE_RST = STYLE_STROBE;

   // =====================================================================
   // Timing: the clock and the hysteresis filter on the reset pin
   localparam int unsigned CLK_PERIOD_NS    = 20;
   localparam int unsigned RST_FILTER_NS    = 80;
   localparam int unsigned RST_FILTER_CYCLES =
      (RST_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // =====================================================================
   // Decoded bus access
   typedef enum logic [2:0]
   {
      ACC_NONE,
      ACC_STATUS_RD,
      ACC_DATA_RD,
      ACC_PARAM_WR,
      ACC_CMD_WR
   } access_t;

endpackage : host_bus_port_pkg

// *** hw/reset_filter.sv ***
// Hysteresis filter for the active-low hardware reset pin.
// Assumes the pin is sampled on the system clock.

`timescale 1ns/10ps

module reset_filter
#(
   parameter int unsigned CYCLES = host_bus_port_pkg::RST_FILTER_CYCLES
)
(
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   // Pin and filtered level
   input  wire logic i_hardware_reset_n,
   output logic      o_reset_active
);
   import host_bus_port_pkg::*;

   localparam int unsigned CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_reg;

   // =====================================================================
   // Level changes only after CYCLES samples of the opposite level
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_reg        <= '0;
         o_reset_active <= 1'b1;
      end
      else if (o_reset_active != !i_hardware_reset_n)
      begin
         if (cnt_reg == CNT_LAST)
         begin
            o_reset_active <= !i_hardware_reset_n;
            cnt_reg        <= '0;
         end
         else
            cnt_reg <= cnt_reg + 1'b1;
      end
      else
         cnt_reg <= '0;
   end

   // =====================================================================
   // Checks
   filter_enter_a: assert property (
      @(posedge i_clk_sys) disable iff (i_rst)
      (!i_hardware_reset_n)[*4] |=> o_reset_active)
      else $error("reset pin held low but filtered reset not active");

   filter_glitch_a: assert property (
      @(posedge i_clk_sys) disable iff (i_rst)
      !o_reset_active ##1 (!i_hardware_reset_n && $past(i_hardware_reset_n))
      ##1 i_hardware_reset_n |=> !o_reset_active)
      else $error("single-cycle glitch reached the filtered reset");

endmodule : reset_filter

// *** hw/host_bus_port.sv ***
// Host-side parallel bus port: strap-selected strobe or enable style,
// access decode, write capture, read drive, clock output and reset pin.
// Assumes all pins are synchronous to i_clk_sys; the core supplies status
// and read data and signals when the system-setup command has executed.
//
// Functional notes
// - Strobe style: select 0/1 read status/data, write parameter/command.
// - Enable style: direction and select give the same four accesses.
// - Strobe style read strobe is active low; bus driven one cycle behind it.
// - Enable style strobe pin is an active-high enable; transfer while high.
// - Strobe style write is active low; data captured at its rising edge.
// - Enable style direction high reads, low writes; device obeys level.
// - Nothing responds unless chip select is low.
// - Active-low hardware reset, through a hysteresis filter, blocks access and stops clock out; data registers keep their values.
// - Clock out follows oscillator, starts after setup command, stops in reset.

`timescale 1ns/10ps

module host_bus_port
(
   // Clock and reset
   input  wire logic                                  i_clk_sys,
   input  wire logic                                  i_rst,
   input  wire logic                                  i_hardware_reset_n,
   // Static strap
   input  wire logic                                  i_bus_style_select,
   // Host bus pins
   input  wire logic                                  i_cs_n,
   input  wire logic                                  i_data_type_select,
   input  wire logic                                  i_rd_n_e,
   input  wire logic                                  i_wr_n_rw,
   input  wire logic [host_bus_port_pkg::DATA_W-1:0]  i_data,
   output logic      [host_bus_port_pkg::DATA_W-1:0]  o_data,
   output logic                                       o_data_oe_n,
   // Oscillator and clock output
   input  wire logic                                  i_osc_in,
   output logic                                       o_osc_out,
   output logic                                       o_buffered_clock_out,
   // Core side
   input  wire logic [host_bus_port_pkg::DATA_W-1:0]  i_status,
   input  wire logic [host_bus_port_pkg::DATA_W-1:0]  i_rd_data,
   input  wire logic                                  i_system_setup_command,
   output logic                                       o_device_reset,
   output logic                                       o_status_rd,
   output logic                                       o_data_rd,
   output logic                                       o_param_wr,
   output logic                                       o_cmd_wr,
   output logic      [host_bus_port_pkg::DATA_W-1:0]  o_wr_data
);
   import host_bus_port_pkg::*;

   logic                dev_rst;
   logic                style_reg;
   logic                rd_act;
   logic                wr_act;
   access_t             access_now;
   access_t             access_reg;
   logic [DATA_W-1:0]   wr_hold_reg;
   logic                clk_run_reg;

   // =====================================================================
   // Filtered hardware reset
   reset_filter #(
      .CYCLES             (RST_FILTER_CYCLES)
   ) u_reset_filter (
      .i_clk_sys          (i_clk_sys),
      .i_rst              (i_rst),
      .i_hardware_reset_n (i_hardware_reset_n),
      .o_reset_active     (dev_rst)
   );

   assign o_device_reset = dev_rst;

   // =====================================================================
   // Strap captured while the device is held in reset, static afterwards
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         style_reg <= STYLE_RST;
      else if (dev_rst)
         style_reg <= i_bus_style_select;
   end

   // =====================================================================
   // Access decode
   always_comb
   begin
      rd_act = 1'b0;
      wr_act = 1'b0;
      if (!i_cs_n && !dev_rst)
      begin
         unique case (style_reg)
            STYLE_STROBE:
            begin
               rd_act = !i_rd_n_e && i_wr_n_rw;
               wr_act = !i_wr_n_rw && i_rd_n_e;
            end
            STYLE_ENABLE:
            begin
               rd_act = i_rd_n_e && i_wr_n_rw;
               wr_act = i_rd_n_e && !i_wr_n_rw;
            end
         endcase
      end
   end

   always_comb
   begin
      if (rd_act)
         access_now = (i_data_type_select == TYPE_LOW) ? ACC_STATUS_RD
                                                       : ACC_DATA_RD;
      else if (wr_act)
         access_now = (i_data_type_select == TYPE_LOW) ? ACC_PARAM_WR
                                                       : ACC_CMD_WR;
      else
         access_now = ACC_NONE;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         access_reg <= ACC_NONE;
      else
         access_reg <= access_now;
   end

   // =====================================================================
   // Write path: data held while the write is active, committed at its end
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         wr_hold_reg <= DATA_RST;
      else if (wr_act)
         wr_hold_reg <= i_data;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_param_wr <= 1'b0;
         o_cmd_wr   <= 1'b0;
         o_wr_data  <= DATA_RST;
      end
      else
      begin
         o_param_wr <= (access_reg == ACC_PARAM_WR) &&
                       (access_now != ACC_PARAM_WR);
         o_cmd_wr   <= (access_reg == ACC_CMD_WR) &&
                       (access_now != ACC_CMD_WR);
         if ((access_reg == ACC_PARAM_WR || access_reg == ACC_CMD_WR) &&
             access_now != access_reg)
            o_wr_data <= wr_hold_reg;
      end
   end

   // =====================================================================
   // Read path: bus driven one cycle behind the read strobe
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_data      <= DATA_RST;
         o_data_oe_n <= 1'b1;
         o_status_rd <= 1'b0;
         o_data_rd   <= 1'b0;
      end
      else
      begin
         o_data_oe_n <= !rd_act;
         o_status_rd <= (access_now == ACC_STATUS_RD) &&
                        (access_reg != ACC_STATUS_RD);
         o_data_rd   <= (access_now == ACC_DATA_RD) &&
                        (access_reg != ACC_DATA_RD);
         if (access_now == ACC_STATUS_RD)
            o_data <= i_status;
         else if (access_now == ACC_DATA_RD)
            o_data <= i_rd_data;
      end
   end

   // =====================================================================
   // Oscillator buffer and gated clock output
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         clk_run_reg <= 1'b0;
      else if (dev_rst)
         clk_run_reg <= 1'b0;
      else if (i_system_setup_command)
         clk_run_reg <= 1'b1;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_buffered_clock_out <= 1'b0;
         o_osc_out            <= 1'b0;
      end
      else
      begin
         o_buffered_clock_out <= clk_run_reg && !dev_rst && i_osc_in;
         // Inverting stage; the pin is unused with an external clock
         o_osc_out            <= !i_osc_in;
      end
   end

   // =====================================================================
   // Checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst || dev_rst);

   read_drive_a: assert property (!i_cs_n && i_wr_n_rw &&
      (style_reg == STYLE_STROBE ? !i_rd_n_e : i_rd_n_e) |=> !o_data_oe_n)
      else $error("read active but data bus not driven");

   bus_release_a: assert property (!rd_act |=> o_data_oe_n)
      else $error("data bus driven with no read active");

   cs_ignore_a: assert property (i_cs_n ##1 i_cs_n |=>
      (o_data_oe_n && !o_cmd_wr && !o_param_wr))
      else $error("response while chip select deasserted");

   strobe_cmd_a: assert property ((style_reg == STYLE_STROBE) &&
      !i_cs_n && !i_wr_n_rw && i_rd_n_e && i_data_type_select
      ##1 i_wr_n_rw |=> (o_cmd_wr && o_wr_data == $past(i_data, 2)))
      else $error("command not captured at write strobe rise");

   enable_param_a: assert property ((style_reg == STYLE_ENABLE) &&
      !i_cs_n && i_rd_n_e && !i_wr_n_rw && !i_data_type_select
      ##1 !i_rd_n_e |=> (o_param_wr && !o_cmd_wr))
      else $error("enable write did not give parameter write");

   strobe_status_a: assert property ((style_reg == STYLE_STROBE) &&
      !i_cs_n && !i_rd_n_e && i_wr_n_rw && !i_data_type_select
      |=> (o_data == $past(i_status)))
      else $error("status read returned wrong value");

   enable_data_a: assert property ((style_reg == STYLE_ENABLE) &&
      !i_cs_n && i_rd_n_e && i_wr_n_rw && i_data_type_select
      |=> (o_data == $past(i_rd_data) && !o_data_oe_n))
      else $error("enable data read returned wrong value");

   enable_dir_a: assert property ((style_reg == STYLE_ENABLE) &&
      i_rd_n_e && !i_wr_n_rw |=> o_data_oe_n)
      else $error("bus driven while direction selects write");

   clk_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      dev_rst |=> !o_buffered_clock_out)
      else $error("clock output toggles during reset");

   clk_follow_a: assert property (clk_run_reg ##1 clk_run_reg
      |-> (o_buffered_clock_out == $past(i_osc_in)))
      else $error("clock output does not follow oscillator");

   osc_inv_a: assert property (o_osc_out == !$past(i_osc_in))
      else $error("oscillator output is not the inverse of its input");

   style_hold_a: assert property (!dev_rst |=> $stable(style_reg))
      else $error("style changed outside reset");

   status_rd_c: cover property (o_status_rd);
   cmd_wr_c:    cover property (o_cmd_wr && style_reg == STYLE_STROBE);
   param_wr_c:  cover property (o_param_wr && style_reg == STYLE_ENABLE);
   clk_run_c:   cover property ($rose(o_buffered_clock_out));

endmodule : host_bus_port

// *** testbench/host_cpu_model.sv ***
// Host processor model driving the parallel port pins.
// Assumes the bench resolves the data wire from both drivers.

`timescale 1ns/10ps

module host_cpu_model
(
   // Clock and strap level
   input  wire logic       i_clk_sys,
   input  wire logic       i_style,
   // Bus pins
   input  wire logic [7:0] i_bus,
   output logic            o_cs_n,
   output logic            o_type,
   output logic            o_rd_n_e,
   output logic            o_wr_n_rw,
   output logic [7:0]      o_data
);
   initial
   begin
      o_cs_n    = 1'b1;
      o_type    = 1'b0;
      o_rd_n_e  = 1'b1;
      o_wr_n_rw = 1'b1;
      o_data    = 8'h00;
   end

   // =====================================================================
   // One transfer: one active cycle, one inactive cycle, then deselect
   task automatic xfer(input logic rd, input logic sel, input logic en,
                       inout logic [7:0] d);
      @(posedge i_clk_sys);
      #1;
      o_cs_n    = ~en;
      o_type    = sel;
      o_rd_n_e  = i_style | ~rd;
      o_wr_n_rw = rd;
      if (!rd) o_data = d;
      @(posedge i_clk_sys);
      #1;
      if (rd) d = i_bus;
      o_rd_n_e  = ~i_style;
      o_wr_n_rw = 1'b1;
      if (!rd) o_data = ~d;
      @(posedge i_clk_sys);
      #1;
      o_cs_n    = 1'b1;
   endtask : xfer

endmodule : host_cpu_model

// *** testbench/host_bus_port_test.sv ***
// Self-checking bench for the host bus port.
// Assumes the host model in host_cpu_model.sv.

`timescale 1ns/10ps

module host_bus_port_test;
   import host_bus_port_pkg::*;

   logic       clk, rst, hw_n, style, osc, setup;
   logic       cs_n, sel, rd_e, wr_rw, oe_n, clko, dev_rst;
   logic       st_rd, d_rd, p_wr, c_wr;
   logic [7:0] host_d, dut_d, bus, wr_data, status, rd_data;
   int         errors, n_checks;
   int         cnt [5];
   int         base [5];

   assign bus = (oe_n === 1'b0) ? dut_d : host_d;

   host_bus_port DUT
   (
      .i_clk_sys(clk), .i_rst(rst), .i_hardware_reset_n(hw_n),
      .i_bus_style_select(style), .i_cs_n(cs_n),
      .i_data_type_select(sel), .i_rd_n_e(rd_e), .i_wr_n_rw(wr_rw),
      .i_data(bus), .o_data(dut_d), .o_data_oe_n(oe_n), .i_osc_in(osc),
      .o_osc_out(),
      .o_buffered_clock_out(clko), .i_status(status),
      .i_rd_data(rd_data), .i_system_setup_command(setup),
      .o_device_reset(dev_rst), .o_status_rd(st_rd), .o_data_rd(d_rd),
      .o_param_wr(p_wr), .o_cmd_wr(c_wr), .o_wr_data(wr_data)
   );

   host_cpu_model HOST
   (
      .i_clk_sys(clk), .i_style(style), .i_bus(bus), .o_cs_n(cs_n),
      .o_type(sel), .o_rd_n_e(rd_e), .o_wr_n_rw(wr_rw), .o_data(host_d)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial
   begin
      osc = 1'b0;
      #5;
      forever #30 osc = ~osc;
   end

   // =====================================================================
   // Pulse and drive counters
   always @(posedge clk)
   begin
      cnt[0] <= cnt[0] + int'(st_rd === 1'b1);
      cnt[1] <= cnt[1] + int'(d_rd === 1'b1);
      cnt[2] <= cnt[2] + int'(p_wr === 1'b1);
      cnt[3] <= cnt[3] + int'(c_wr === 1'b1);
      cnt[4] <= cnt[4] + int'(oe_n === 1'b0);
   end

   // =====================================================================
   // Shared tasks
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic pulses(input logic [4:0] exp);
      int i;
      for (i = 0; i < 5; i++)
         check(8'(i < 4 ? cnt[i] - base[i] : cnt[i] != base[i]),
               8'(exp[i]));
      base = cnt;
   endtask : pulses

   task automatic wait_rst(input logic lvl);
      int i;
      for (i = 0; i < 20 && dev_rst !== lvl; i++)
         cyc(1);
      check(8'(dev_rst), 8'(lvl));
      if (dev_rst !== lvl)
         stop_test();
   endtask : wait_rst

   // =====================================================================
   // Scenarios
   task automatic t_access(input logic en);
      logic [7:0] d, last;
      int k;
      last = wr_data;
      for (k = 0; k < 2; k++)
      begin
         base = cnt;
         d = k ? 8'hc5 : 8'h3a;
         HOST.xfer(1'b0, k[0], en, d);
         cyc(2);
         check(wr_data, en ? d : last);
         pulses(en ? (k ? 5'b01000 : 5'b00100) : 5'b0);
         HOST.xfer(1'b1, k[0], en, d);
         cyc(2);
         if (en) check(d, k ? rd_data : status);
         pulses(en ? (k ? 5'b10010 : 5'b10001) : 5'b0);
         check(8'(oe_n), 8'h01);
      end
   endtask : t_access

   task automatic t_clock();
      logic v;
      int i;
      for (i = 0; i < 6; i++)
      begin
         cyc(1);
         check(8'(clko), 8'h00);
      end
      setup = 1'b1;
      cyc(1);
      setup = 1'b0;
      cyc(2);
      for (i = 0; i < 8; i++)
      begin
         @(posedge clk);
         v = osc;
         #1;
         check(8'(clko), 8'(v));
      end
   endtask : t_clock

   // =====================================================================
   // Main sequence
   initial
   begin
      rst = 1'b1;
      hw_n = 1'b1;
      style = STYLE_STROBE;
      setup = 1'b0;
      status = 8'h96;
      rd_data = 8'h4b;
      errors = 0;
      n_checks = 0;
      cnt = '{default: 0};
      base = cnt;
      cyc(10);
      check({6'h0, oe_n, dev_rst}, 8'h03);
      check(8'(clko), 8'h00);
      rst = 1'b0;
      wait_rst(1'b0);
      t_access(1'b1);
      t_access(1'b0);
      hw_n = 1'b0;
      cyc(2);
      hw_n = 1'b1;
      cyc(4);
      check(8'(dev_rst), 8'h00);
      hw_n = 1'b0;
      cyc(1);
      hw_n = 1'b1;
      cyc(4);
      check(8'(dev_rst), 8'h00);
      t_clock();
      hw_n = 1'b0;
      wait_rst(1'b1);
      cyc(2);
      check({6'h0, oe_n, clko}, 8'h02);
      style = STYLE_ENABLE;
      hw_n = 1'b1;
      wait_rst(1'b0);
      status = 8'h2d;
      rd_data = 8'he1;
      t_access(1'b1);
      stop_test();
   end

endmodule : host_bus_port_test
